// [verilog/xdm_stretch_mem.sv]
// External data memory access with programmable stretch and dual data pointers.
// Notes on behaviour
// - Every machine cycle is four clocks and the fetch pace never depends on stretch.
// - Off-chip memory is reached by multiplexed low address and data on port zero, high address on port two.
// - Bits 2 to 0 of the clock control register at 8Eh hold a stretch value of zero to seven.
// - A data move takes two machine cycles at stretch zero and nine at stretch seven.
// - A move lasts stretch plus two cycles; the strobe is 2 clocks at zero and 4 clocks per step otherwise.
// - After reset the stretch value is one, giving three-cycle moves.
// - Software may rewrite the stretch at any time and each later move uses the new value.
// - For stretch one to seven the strobe and its related timing are lengthened.
// - Stretch applies to data moves only; fetch timing is unchanged.
// - The first pointer sits at 82h low and 83h high.
// - The second pointer sits at 84h low and 85h high.
// - Bit 0 of the register at 86h selects the pointer; the other bits read zero.
// - Every pointer operation, moves and increments, uses the selected pointer.
// - Incrementing the select register toggles its low bit and so switches pointer.
// - One address latch pulse is emitted in every four-clock machine cycle.
`timescale 1ns/1ps
`default_nettype none
module xdm_stretch_mem
  import xdm_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_write,
  input  wire logic       i_reg_read,
  input  wire logic       i_sel_increment,
  output logic      [7:0] o_reg_rdata,
  output logic            o_ale,
  output logic      [7:0] o_port_zero_out,
  output logic            o_port_zero_oe_n,
  input  wire logic [7:0] i_port_zero_in,
  output logic      [7:0] o_port_two,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_busy
);
  typedef enum logic [2:0] {XDM_IDLE, XDM_WAIT, XDM_ADDR, XDM_DATA, XDM_HOLD} xdm_state_t;

  xdm_state_t  state;
  logic [15:0] first_data_pointer [2];
  logic        sel;
  logic [7:0]  clk_ctrl;
  logic [7:0]  move_data;
  logic        pend_go;
  logic        pend_wr;
  logic        pend_inc;
  logic        op_wr;
  logic        op_inc;
  logic        op_sel;
  logic [4:0]  cnt;
  logic [4:0]  strobe_len;
  logic [2:0]  stretch;
  logic        cycle_start;
  logic        ale_pulse;
  logic [7:0]  p0_sync1;
  logic [7:0]  p0_sync2;
  logic        wr_first_data_pointer;
  logic        wr_sel;
  logic        wr_ctrl;
  logic        op_short;
  logic [4:0]  hold_len;
  logic        move_start;
  logic        addr_last;
  logic        data_last;
  logic        move_last;
  logic        rd_capture;

  function automatic logic is_write(input logic [7:0] addr, input logic [7:0] target,
                                    input logic we);
    is_write = we && (addr == target);
  endfunction : is_write

  ////////////////////////////////////////////////////////////////////////////////
  // Machine cycle pacing, shared with fetch and never altered by stretch.

  xdm_cycle_timer #(
    .CLOCKS (CLOCKS_PER_CYCLE)
  ) u_timer (
    .i_clock       (i_clock),
    .i_rst_n       (i_rst_n),
    .o_cycle_start (cycle_start),
    .o_ale         (ale_pulse)
  );

  assign o_ale = ale_pulse;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  assign stretch = clk_ctrl[STRETCH_MSB:STRETCH_LSB];
  assign wr_sel  = is_write(i_reg_addr, ADDR_PTR_SELECT, i_reg_write);
  assign wr_ctrl = is_write(i_reg_addr, ADDR_MOVE_CTRL, i_reg_write);
  assign wr_first_data_pointer = i_reg_write && (i_reg_addr >= ADDR_DPTR0_LO)
                && (i_reg_addr <= ADDR_SECOND_DATA_POINTER_HI);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      clk_ctrl <= {5'h00, STRETCH_RESET};
    end else if (is_write(i_reg_addr, ADDR_CLK_CTRL, i_reg_write)) begin
      clk_ctrl <= i_reg_wdata & CLK_CTRL_WMASK;
    end
  end

  // Only bit 0 is kept, so an increment of the register is a toggle.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sel <= 1'b0;
    end else if (wr_sel) begin
      sel <= i_reg_wdata[0];
    end else if (i_sel_increment) begin
      sel <= ~sel;
    end
  end

  // A software write to either pointer wins over a move's post increment in that cycle.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      first_data_pointer[0] <= 16'h0000;
      first_data_pointer[1] <= 16'h0000;
    end else begin
      case (i_reg_addr)
        ADDR_DPTR0_LO: if (i_reg_write) first_data_pointer[0][7:0]  <= i_reg_wdata;
        ADDR_DPTR0_HI: if (i_reg_write) first_data_pointer[0][15:8] <= i_reg_wdata;
        ADDR_SECOND_DATA_POINTER_LO: if (i_reg_write) first_data_pointer[1][7:0]  <= i_reg_wdata;
        ADDR_SECOND_DATA_POINTER_HI: if (i_reg_write) first_data_pointer[1][15:8] <= i_reg_wdata;
        default: ;
      endcase
      if (move_last && op_inc && !wr_first_data_pointer) begin
        first_data_pointer[op_sel] <= first_data_pointer[op_sel] + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_read) begin
      case (i_reg_addr)
        ADDR_DPTR0_LO:   o_reg_rdata <= first_data_pointer[0][7:0];
        ADDR_DPTR0_HI:   o_reg_rdata <= first_data_pointer[0][15:8];
        ADDR_SECOND_DATA_POINTER_LO:   o_reg_rdata <= first_data_pointer[1][7:0];
        ADDR_SECOND_DATA_POINTER_HI:   o_reg_rdata <= first_data_pointer[1][15:8];
        ADDR_PTR_SELECT: o_reg_rdata <= {7'h00, sel};
        ADDR_CLK_CTRL:   o_reg_rdata <= clk_ctrl;
        ADDR_MOVE_DATA:  o_reg_rdata <= move_data;
        ADDR_MOVE_STAT:  o_reg_rdata <= {7'h00, o_busy};
        default:         o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Move request: taken only while no move is pending or running, started at the next machine cycle boundary.

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pend_go  <= 1'b0;
      pend_wr  <= 1'b0;
      pend_inc <= 1'b0;
    end else if (wr_ctrl && i_reg_wdata[MOVE_CTRL_GO] && state == XDM_IDLE && !pend_go) begin
      pend_go  <= 1'b1;
      pend_wr  <= i_reg_wdata[MOVE_CTRL_WR];
      pend_inc <= i_reg_wdata[MOVE_CTRL_INC];
    end else if (state == XDM_WAIT && cycle_start) begin
      pend_go <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      move_data <= 8'h00;
    end else if (is_write(i_reg_addr, ADDR_MOVE_DATA, i_reg_write) && !o_busy) begin
      move_data <= i_reg_wdata;
    end else if (rd_capture) begin
      move_data <= p0_sync2;
    end
  end

  // Read data come from a pin, so they pass two flip-flops first.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      p0_sync1 <= 8'h00;
      p0_sync2 <= 8'h00;
    end else begin
      p0_sync1 <= i_port_zero_in;
      p0_sync2 <= p0_sync1;
    end
  end

  // Stretch is read once, at the end of the address cycle, so a rewrite made after the
  // address cycle of a move changes only the moves that follow it.
  assign strobe_len = (stretch == 3'h0) ? STROBE_ZERO_CLOCKS
                    : 5'(stretch * STROBE_STEP_CLOCKS);

  // After the strobe the bus rests until the move fills whole machine cycles.
  assign hold_len = op_short ? (STROBE_STEP_CLOCKS - STROBE_ZERO_CLOCKS)
                  : STROBE_STEP_CLOCKS;

  ////////////////////////////////////////////////////////////////////////////////
  // Move sequencer: address cycle, strobe phase, rest; stretch plus two cycles in all.

  assign move_start = (state == XDM_WAIT) && cycle_start;
  assign addr_last  = (state == XDM_ADDR) && (cnt == 5'h01);
  assign data_last  = (state == XDM_DATA) && (cnt == 5'h01);
  assign move_last  = (state == XDM_HOLD) && (cnt == 5'h01);
  // The pin is two flip-flops behind, so this takes the value that stood at the last
  // clock of the read strobe; the part must answer within the strobe itself.
  assign rd_capture = (state == XDM_HOLD) && !op_wr && (cnt == hold_len - 5'h01);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= XDM_IDLE;
    end else begin
      case (state)
        XDM_IDLE: begin
          if (pend_go) begin
            state <= XDM_WAIT;
          end
        end
        XDM_WAIT: begin
          if (cycle_start) begin
            state <= XDM_ADDR;
          end
        end
        XDM_ADDR: begin
          if (cnt == 5'h01) begin
            state <= XDM_DATA;
          end
        end
        XDM_DATA: begin
          if (cnt == 5'h01) begin
            state <= XDM_HOLD;
          end
        end
        XDM_HOLD: begin
          if (cnt == 5'h01) begin
            state <= XDM_IDLE;
          end
        end
        default: state <= XDM_IDLE;
      endcase
    end
  end

  // One counter times every phase; it rests at zero between moves.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt <= 5'h00;
    end else if (move_start) begin
      cnt <= ADDR_PHASE_CLOCKS;
    end else if (addr_last) begin
      cnt <= strobe_len;
    end else if (data_last) begin
      cnt <= hold_len;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      op_wr  <= 1'b0;
      op_inc <= 1'b0;
      op_sel <= 1'b0;
    end else if (move_start) begin
      op_wr  <= pend_wr;
      op_inc <= pend_inc;
      op_sel <= sel;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      op_short <= 1'b0;
    end else if (addr_last) begin
      op_short <= (stretch == 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered; o_busy is combined from pend_go and the state.

  // Port zero carries the low address first and the write data from the strobe on.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_port_zero_out <= 8'h00;
    end else if (move_start) begin
      o_port_zero_out <= first_data_pointer[sel][7:0];
    end else if (addr_last) begin
      o_port_zero_out <= move_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_port_zero_oe_n <= 1'b1;
    end else if (move_start) begin
      o_port_zero_oe_n <= 1'b0;
    end else if (addr_last) begin
      o_port_zero_oe_n <= !op_wr;
    end else if (move_last) begin
      o_port_zero_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_port_two <= 8'h00;
    end else if (move_start) begin
      o_port_two <= first_data_pointer[sel][15:8];
    end
  end

  // Each strobe is low for the whole data phase, whose length the stretch sets.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rd_n <= 1'b1;
    end else if (addr_last) begin
      o_rd_n <= op_wr;
    end else if (data_last) begin
      o_rd_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wr_n <= 1'b1;
    end else if (addr_last) begin
      o_wr_n <= !op_wr;
    end else if (data_last) begin
      o_wr_n <= 1'b1;
    end
  end

  assign o_busy = pend_go || (state != XDM_IDLE);
endmodule : xdm_stretch_mem
`default_nettype wire

// [verilog/xdm_pkg.sv]
// Package of constants for the external data memory stretch and dual pointer block.
package xdm_pkg;
  localparam int unsigned CLOCKS_PER_CYCLE = 4;
  localparam logic [7:0] ADDR_DPTR0_LO   = 8'h82;
  localparam logic [7:0] ADDR_DPTR0_HI   = 8'h83;
  localparam logic [7:0] ADDR_SECOND_DATA_POINTER_LO   = 8'h84;
  localparam logic [7:0] ADDR_SECOND_DATA_POINTER_HI   = 8'h85;
  localparam logic [7:0] ADDR_PTR_SELECT = 8'h86;
  localparam logic [7:0] ADDR_CLK_CTRL   = 8'h8e;
  localparam logic [7:0] ADDR_MOVE_CTRL  = 8'hf0;
  localparam logic [7:0] ADDR_MOVE_DATA  = 8'hf1;
  localparam logic [7:0] ADDR_MOVE_STAT  = 8'hf2;
  localparam int unsigned STRETCH_LSB = 0;
  localparam int unsigned STRETCH_MSB = 2;
  localparam logic [2:0] STRETCH_RESET = 3'h1;
  localparam logic [7:0] CLK_CTRL_WMASK = 8'h3f;
  localparam int unsigned MOVE_CTRL_GO  = 0;
  localparam int unsigned MOVE_CTRL_WR  = 1;
  localparam int unsigned MOVE_CTRL_INC = 2;
  localparam int unsigned MOVE_STAT_BUSY = 0;
  localparam logic [4:0] STROBE_ZERO_CLOCKS = 5'h02;
  localparam logic [4:0] STROBE_STEP_CLOCKS = 5'h04;
  localparam logic [4:0] ADDR_PHASE_CLOCKS  = 5'h04;
endpackage : xdm_pkg

// [verilog/xdm_cycle_timer.sv]
// Machine-cycle divider that makes one address latch pulse per four clocks.
`timescale 1ns/1ps
`default_nettype none
module xdm_cycle_timer
  import xdm_pkg::*;
#(
  parameter int unsigned CLOCKS = CLOCKS_PER_CYCLE
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  output logic      o_cycle_start,
  output logic      o_ale
);
  logic [1:0] phase;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      phase <= 2'h0;
    end else if (phase == 2'(CLOCKS - 1)) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // The latch pulse is a register so it is glitch free at the pin.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_ale <= 1'b0;
    end else begin
      o_ale <= (phase == 2'(CLOCKS - 1));
    end
  end

  assign o_cycle_start = (phase == 2'h0);
endmodule : xdm_cycle_timer
`default_nettype wire

// [test/xdm_stretch_mem_sva.sv]
// Port timing checker for the external data memory stretch block.
`timescale 1ns/1ps
`default_nettype none
module xdm_stretch_mem_sva
  import xdm_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_write,
  input wire logic       i_reg_read,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_ale,
  input wire logic       o_port_zero_oe_n,
  input wire logic [7:0] o_port_two,
  input wire logic       o_rd_n,
  input wire logic       o_wr_n,
  input wire logic       o_busy
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  AST_ALE_PERIOD: assert property (o_ale |=> !o_ale [*3] ##1 o_ale)
    else $error("ale period wrong");
  AST_WR_DRIVE: assert property (!o_wr_n |-> !o_port_zero_oe_n)
    else $error("port zero not driven during write");
  AST_RD_RELEASE: assert property (!o_rd_n |-> o_port_zero_oe_n)
    else $error("port zero driven during read");
  AST_STROBE_MIN: assert property ($fell(o_wr_n) |=> !o_wr_n)
    else $error("write strobe too short");
  AST_STROBE_MAX: assert property ($fell(o_rd_n) |-> ##[2:28] o_rd_n)
    else $error("read strobe too long");
  AST_MOVE_GO: assert property (i_reg_write && i_reg_addr == ADDR_MOVE_CTRL && i_reg_wdata[0] && !o_busy |=> o_busy)
    else $error("move request not taken");
  AST_MOVE_LEN: assert property ($rose(o_busy) |-> ##[10:41] !o_busy)
    else $error("move length out of range");
  AST_P2_STABLE: assert property (!o_rd_n || !o_wr_n |-> $stable(o_port_two))
    else $error("high address moved under strobe");
  AST_SEL_READ: assert property ($past(i_reg_read) && $past(i_reg_addr) == ADDR_PTR_SELECT |-> o_reg_rdata[7:1] == 7'h00)
    else $error("select upper bits not zero");
endmodule : xdm_stretch_mem_sva
bind xdm_stretch_mem xdm_stretch_mem_sva u_sva (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
  .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .o_ale(o_ale),
  .o_port_zero_oe_n(o_port_zero_oe_n), .o_port_two(o_port_two), .o_rd_n(o_rd_n),
  .o_wr_n(o_wr_n), .o_busy(o_busy));
`default_nettype wire

// [test/xdm_ext_ram.sv]
// Behavioural external memory on the multiplexed bus.
`timescale 1ns/1ps
`default_nettype none
module xdm_ext_ram (
  input  wire logic       i_clock,
  input  wire logic       i_ale,
  input  wire logic [7:0] i_port_zero,
  input  wire logic       i_oe_n,
  input  wire logic [7:0] i_port_two,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [4:0] i_delay,
  output logic      [7:0] o_data
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic [7:0]  last = 8'h00;
  logic [4:0]  age  = 5'h00;
  always @(posedge i_clock) begin
    if (i_ale && i_rd_n && i_wr_n && !i_oe_n) begin
      addr <= {i_port_two, i_port_zero};
    end
    if (!i_wr_n) begin
      mem[addr] <= i_port_zero;
    end
    age  <= (i_rd_n !== 1'b0) ? 5'h00 : age + 5'h01;
    last <= o_data;
  end
  // Outside a valid read the bus toggles, so stale data can never pass as a match.
  assign o_data = (i_rd_n === 1'b0 && age >= i_delay) ? mem[addr] : ~last;
endmodule : xdm_ext_ram
`default_nettype wire

// [test/xdm_stretch_mem_test.sv]
// Self-checking testbench for the external data memory stretch block.
`timescale 1ns/1ps
`default_nettype none
module xdm_stretch_mem_test;
  import xdm_pkg::*;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       inc   = 1'b0;
  logic [4:0] dly   = 5'h00;
  logic [7:0] rdata, p0_out, p0_in, p2;
  logic       ale, oe_n, rd_n, wr_n, busy;
  int         err_count  = 0;
  int         num_checks = 0;
  always #25 clk = ~clk;
  xdm_stretch_mem u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd), .i_sel_increment(inc),
    .o_reg_rdata(rdata), .o_ale(ale), .o_port_zero_out(p0_out), .o_port_zero_oe_n(oe_n),
    .i_port_zero_in(p0_in), .o_port_two(p2), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_busy(busy));
  xdm_ext_ram u_ram (.i_clock(clk), .i_ale(ale), .i_port_zero(p0_out), .i_oe_n(oe_n),
    .i_port_two(p2), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_delay(dly), .o_data(p0_in));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : reg_rd
  task automatic pulse_inc();
    @(posedge clk);
    inc <= 1'b1;
    @(posedge clk);
    inc <= 1'b0;
  endtask : pulse_inc
  // Counts busy cycles and strobe-low cycles; the bound stops a dead move from hanging.
  task automatic move(input int s, input logic w, output logic [7:0] width);
    int n;
    n = 0;
    width = 8'h00;
    reg_wr(ADDR_MOVE_CTRL, {5'h00, w, w, 1'b1});
    do begin
      @(negedge clk);
      n++;
      if (rd_n === 1'b0 || wr_n === 1'b0) width++;
    end while (busy === 1'b1 && n < 60);
    chk({7'h00, n >= (s + 2) * 4 && n <= (s + 2) * 4 + 6}, 8'h01);
  endtask : move
  ////////////////////////////////////////
  task automatic t_reset();
    reg_rd(ADDR_DPTR0_LO, 8'h00);
    reg_rd(ADDR_DPTR0_HI, 8'h00);
    reg_rd(ADDR_SECOND_DATA_POINTER_LO, 8'h00);
    reg_rd(ADDR_SECOND_DATA_POINTER_HI, 8'h00);
    reg_rd(ADDR_PTR_SELECT, 8'h00);
    reg_rd(ADDR_CLK_CTRL, 8'h01);
    reg_rd(ADDR_MOVE_STAT, 8'h00);
  endtask : t_reset
  task automatic t_default();
    logic [7:0] w;
    move(1, 1'b1, w);
    chk(w, 8'h04);
    reg_rd(ADDR_DPTR0_LO, 8'h01);
  endtask : t_default
  task automatic t_regs();
    reg_wr(ADDR_PTR_SELECT, 8'hff);
    reg_rd(ADDR_PTR_SELECT, 8'h01);
    pulse_inc();
    reg_rd(ADDR_PTR_SELECT, 8'h00);
    pulse_inc();
    reg_rd(ADDR_PTR_SELECT, 8'h01);
    reg_wr(ADDR_CLK_CTRL, 8'hff);
    reg_rd(ADDR_CLK_CTRL, CLK_CTRL_WMASK);
    reg_wr(ADDR_DPTR0_HI, 8'h3c);
    reg_rd(ADDR_DPTR0_HI, 8'h3c);
    reg_rd(8'h81, 8'h00);
  endtask : t_regs
  task automatic t_moves();
    logic [7:0] w;
    for (int s = 0; s < 8; s++) begin
      dly <= (s > 1) ? 5'(s) : 5'h00;
      reg_wr(ADDR_CLK_CTRL, 8'(s));
      reg_wr(ADDR_SECOND_DATA_POINTER_LO, 8'h10 + 8'(s));
      reg_wr(ADDR_SECOND_DATA_POINTER_HI, 8'h5a);
      reg_wr(ADDR_MOVE_DATA, 8'ha0 + 8'(s));
      move(s, 1'b1, w);
      chk(w, (s == 0) ? 8'h02 : 8'(4 * s));
      chk(p2, 8'h5a);
      reg_rd(ADDR_SECOND_DATA_POINTER_LO, 8'h11 + 8'(s));
      reg_wr(ADDR_SECOND_DATA_POINTER_LO, 8'h10 + 8'(s));
      move(s, 1'b0, w);
      reg_rd(ADDR_MOVE_DATA, 8'ha0 + 8'(s));
    end
    reg_rd(ADDR_DPTR0_LO, 8'h01);
  endtask : t_moves
  task automatic results();
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_default();
    t_regs();
    t_moves();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule : xdm_stretch_mem_test
`default_nettype wire
